// ===== ersseq_defines.svh
`ifndef ERSSEQ_DEFINES_SVH
`define ERSSEQ_DEFINES_SVH

// Clock
`define ERSSEQ_CLK_HZ 200000000
`define ERSSEQ_CLK_PERIOD_NS 5

// Times as printed
`define ERSSEQ_STOP_TIME_S 1
`define ERSSEQ_DEASSERT_MIN_NS 1200

// Derived cycle counts
`define ERSSEQ_STOP_CYCLES (`ERSSEQ_STOP_TIME_S * `ERSSEQ_CLK_HZ)
`define ERSSEQ_DEASSERT_CYCLES \
  ((`ERSSEQ_DEASSERT_MIN_NS + `ERSSEQ_CLK_PERIOD_NS - 1) / `ERSSEQ_CLK_PERIOD_NS)

// Widths
`define ERSSEQ_CNT_W 32
`define ERSSEQ_FILT_W 8

// Reset values
`define ERSSEQ_SERIAL_EN_RST 1'b1
`define ERSSEQ_OFF_RST 1'b0

`endif

// ===== ersseq_pkg.sv
`include "ersseq_defines.svh"

package ersseq_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_RUN,
    ST_STOP,
    ST_RST_STOP,
    ST_RELOAD,
    ST_RST_HOLD
  } ersseq_state_t;

  typedef logic [`ERSSEQ_CNT_W-1:0] ersseq_cnt_t;
  typedef logic [`ERSSEQ_FILT_W-1:0] ersseq_filt_t;

endpackage : ersseq_pkg

// ===== ersseq_cond_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ersseq_cond_if;
  logic enable_raw;
  logic reset_raw;
  logic speed_raw;
  logic polarity;
  logic enable_ok;
  logic reset_ok;
  logic speed_edge;

  modport cond (
    input enable_raw,
    input reset_raw,
    input speed_raw,
    input polarity,
    output enable_ok,
    output reset_ok,
    output speed_edge
  );

  modport core (
    output enable_raw,
    output reset_raw,
    output speed_raw,
    output polarity,
    input enable_ok,
    input reset_ok,
    input speed_edge
  );
endinterface : ersseq_cond_if

`default_nettype wire

// ===== ersseq_cond.sv
`timescale 1ns/1ps
`default_nettype none
`include "ersseq_defines.svh"

module ersseq_cond (
  input wire logic clk,
  input wire logic reset_n,
  ersseq_cond_if.cond cif
);

  localparam ersseq_pkg::ersseq_filt_t FILT_LIM =
    `ERSSEQ_FILT_W'(`ERSSEQ_DEASSERT_CYCLES);

  logic [1:0] en_sync_q, en_sync_d;
  logic [1:0] rst_sync_q, rst_sync_d;
  logic [2:0] spd_sync_q, spd_sync_d;
  ersseq_pkg::ersseq_filt_t filt_q, filt_d;
  logic en_ok_q, en_ok_d;
  logic eff_active;

  // Pin synchronisers, then level filter on effective enable
  always_comb begin
    en_sync_d = {en_sync_q[0], cif.enable_raw};
    rst_sync_d = {rst_sync_q[0], cif.reset_raw};
    spd_sync_d = {spd_sync_q[1:0], cif.speed_raw};
    eff_active = en_sync_q[1] ^ cif.polarity;
    filt_d = '0;
    en_ok_d = en_ok_q;
    if (eff_active != en_ok_q) begin
      if (filt_q == FILT_LIM - 1'b1) begin
        en_ok_d = eff_active;
      end else begin
        filt_d = filt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_sync_q <= '0;
      rst_sync_q <= '0;
      spd_sync_q <= '0;
      filt_q <= '0;
      en_ok_q <= 1'b0;
    end else begin
      en_sync_q <= en_sync_d;
      rst_sync_q <= rst_sync_d;
      spd_sync_q <= spd_sync_d;
      filt_q <= filt_d;
      en_ok_q <= en_ok_d;
    end
  end

  assign cif.enable_ok = en_ok_q;
  assign cif.reset_ok = rst_sync_q[1];
  assign cif.speed_edge = spd_sync_q[2] ^ spd_sync_q[1];

  property p_filter_change;
    @(posedge clk) disable iff (!reset_n)
      (en_ok_q != en_ok_d) |-> filt_q == FILT_LIM - 1'b1;
  endproperty
  a_filter_change: assert property (p_filter_change)
    else $error("Enable level changed before filter time");

endmodule : ersseq_cond

`default_nettype wire

// ===== ersseq_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ersseq_defines.svh"

module ersseq_top #(
  parameter ersseq_pkg::ersseq_cnt_t STOP_CYCLES =
    `ERSSEQ_CNT_W'(`ERSSEQ_STOP_CYCLES)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable_pin,
  input wire logic reset_pin,
  input wire logic speed_pulse_out,
  input wire logic brake_mode_select,
  input wire logic enable_polarity,
  output logic motor_en_q,
  output logic brake_q,
  output logic core_power_q,
  output logic sensor_supply_en_q,
  output logic power_switch_en_q,
  output logic clocks_run_q,
  output logic logic_en_q,
  output logic serial_if_en_q,
  output logic otp_reload_q,
  output logic fault_clear_q,
  output logic datapath_init_q,
  output logic reset_pending_q
);

  ersseq_cond_if cif ();

  assign cif.enable_raw = enable_pin;
  assign cif.reset_raw = reset_pin;
  assign cif.speed_raw = speed_pulse_out;
  assign cif.polarity = enable_polarity;

  ersseq_cond u_cond (
    .clk(clk),
    .reset_n(reset_n),
    .cif(cif.cond)
  );

  // Last count of a stopped interval
  function automatic logic at_limit(
    input ersseq_pkg::ersseq_cnt_t cnt,
    input ersseq_pkg::ersseq_cnt_t lim
  );
    return cnt == lim - 1'b1;
  endfunction : at_limit

  // Quiet-time counter step shared by both stop states
  function automatic ersseq_pkg::ersseq_cnt_t quiet_next(
    input logic edge_seen,
    input ersseq_pkg::ersseq_cnt_t cnt
  );
    return edge_seen ? '0 : cnt + 1'b1;
  endfunction : quiet_next

  ersseq_pkg::ersseq_state_t state_q, state_d;
  ersseq_pkg::ersseq_cnt_t quiet_q, quiet_d;
  logic pend_d;
  logic pol_q, pol_d;
  logic pol_change;

  assign pol_change = enable_polarity != pol_q;

  // Sequencer
  always_comb begin
    state_d = state_q;
    quiet_d = quiet_q;
    pend_d = reset_pending_q;
    pol_d = enable_polarity;
    case (state_q)
      ersseq_pkg::ST_RUN: begin
        if (!cif.enable_ok || pol_change) begin
          state_d = ersseq_pkg::ST_STOP;
          quiet_d = '0;
          pend_d = cif.reset_ok;
        end else if (cif.reset_ok) begin
          state_d = ersseq_pkg::ST_RST_STOP;
          quiet_d = '0;
        end
      end
      ersseq_pkg::ST_STOP: begin
        if (cif.reset_ok) begin
          pend_d = 1'b1;
        end
        if (!cif.speed_edge && at_limit(quiet_q, STOP_CYCLES)) begin
          state_d = ersseq_pkg::ST_SLEEP;
          quiet_d = '0;
        end else begin
          quiet_d = quiet_next(cif.speed_edge, quiet_q);
        end
      end
      ersseq_pkg::ST_SLEEP: begin
        if (cif.reset_ok) begin
          pend_d = 1'b1;
        end
        if (cif.enable_ok) begin
          if (pend_d) begin
            state_d = ersseq_pkg::ST_RELOAD;
          end else begin
            state_d = ersseq_pkg::ST_RUN;
          end
        end
      end
      ersseq_pkg::ST_RST_STOP: begin
        if (!cif.speed_edge && at_limit(quiet_q, STOP_CYCLES)) begin
          state_d = ersseq_pkg::ST_RELOAD;
          quiet_d = '0;
        end else begin
          quiet_d = quiet_next(cif.speed_edge, quiet_q);
        end
      end
      ersseq_pkg::ST_RELOAD: begin
        pend_d = 1'b0;
        if (cif.reset_ok) begin
          state_d = ersseq_pkg::ST_RST_HOLD;
        end else if (cif.enable_ok) begin
          state_d = ersseq_pkg::ST_RUN;
        end else begin
          state_d = ersseq_pkg::ST_SLEEP;
        end
      end
      ersseq_pkg::ST_RST_HOLD: begin
        if (!cif.reset_ok) begin
          if (cif.enable_ok) begin
            state_d = ersseq_pkg::ST_RUN;
          end else begin
            state_d = ersseq_pkg::ST_SLEEP;
          end
        end
      end
      default: begin
        state_d = ersseq_pkg::ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ersseq_pkg::ST_SLEEP;
      quiet_q <= '0;
      reset_pending_q <= 1'b0;
      pol_q <= 1'b0;
    end else begin
      state_q <= state_d;
      quiet_q <= quiet_d;
      reset_pending_q <= pend_d;
      pol_q <= pol_d;
    end
  end

  // Output controls, registered from next state
  logic motor_en_d;
  logic brake_d;
  logic awake_d;
  logic reload_d;

  always_comb begin
    motor_en_d = state_d == ersseq_pkg::ST_RUN;
    awake_d = state_d != ersseq_pkg::ST_SLEEP;
    brake_d = awake_d && !motor_en_d && brake_mode_select;
    reload_d = state_d == ersseq_pkg::ST_RELOAD;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      motor_en_q <= `ERSSEQ_OFF_RST;
      brake_q <= `ERSSEQ_OFF_RST;
      core_power_q <= `ERSSEQ_OFF_RST;
      sensor_supply_en_q <= `ERSSEQ_OFF_RST;
      power_switch_en_q <= `ERSSEQ_OFF_RST;
      clocks_run_q <= `ERSSEQ_OFF_RST;
      logic_en_q <= `ERSSEQ_OFF_RST;
      serial_if_en_q <= `ERSSEQ_SERIAL_EN_RST;
      otp_reload_q <= `ERSSEQ_OFF_RST;
      fault_clear_q <= `ERSSEQ_OFF_RST;
      datapath_init_q <= `ERSSEQ_OFF_RST;
    end else begin
      motor_en_q <= motor_en_d;
      brake_q <= brake_d;
      core_power_q <= awake_d;
      sensor_supply_en_q <= awake_d;
      power_switch_en_q <= awake_d;
      clocks_run_q <= awake_d;
      logic_en_q <= awake_d;
      serial_if_en_q <= 1'b1;
      otp_reload_q <= reload_d;
      fault_clear_q <= reload_d;
      datapath_init_q <= reload_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_run_to_stop;
    state_q == ersseq_pkg::ST_RUN && !cif.enable_ok
      |=> state_q == ersseq_pkg::ST_STOP;
  endproperty
  a_run_to_stop: assert property (p_run_to_stop)
    else $error("Enable deassertion did not start stop");

  property p_stop_drive;
    state_q == ersseq_pkg::ST_STOP
      |-> !motor_en_q && brake_q == $past(brake_mode_select);
  endproperty
  a_stop_drive: assert property (p_stop_drive)
    else $error("Motor not disabled as selected in stop");

  property p_quiet_needed;
    state_q == ersseq_pkg::ST_STOP && !at_limit(quiet_q, STOP_CYCLES)
      |=> state_q != ersseq_pkg::ST_SLEEP;
  endproperty
  a_quiet_needed: assert property (p_quiet_needed)
    else $error("Slept before full stopped interval");

  property p_edge_restarts;
    state_q == ersseq_pkg::ST_STOP && cif.speed_edge |=> quiet_q == '0;
  endproperty
  a_edge_restarts: assert property (p_edge_restarts)
    else $error("Speed edge did not restart quiet time");

  property p_sleep_off;
    state_q == ersseq_pkg::ST_SLEEP
      |-> !core_power_q && !sensor_supply_en_q && !power_switch_en_q
          && !clocks_run_q;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("Power still on in sleep");

  property p_serial_alive;
    state_q == ersseq_pkg::ST_SLEEP ##1 state_q == ersseq_pkg::ST_SLEEP
      |-> serial_if_en_q;
  endproperty
  a_serial_alive: assert property (p_serial_alive)
    else $error("Serial interface off in sleep");

  property p_sleep_logic;
    state_q == ersseq_pkg::ST_SLEEP |-> !logic_en_q && !motor_en_q;
  endproperty
  a_sleep_logic: assert property (p_sleep_logic)
    else $error("Logic left enabled in sleep");

  property p_pol_stop;
    state_q == ersseq_pkg::ST_RUN && enable_polarity != $past(enable_polarity)
      |=> state_q == ersseq_pkg::ST_STOP;
  endproperty
  a_pol_stop: assert property (p_pol_stop)
    else $error("Polarity change did not start stop");

  property p_stop_holds;
    state_q == ersseq_pkg::ST_STOP
      |=> state_q inside {ersseq_pkg::ST_STOP, ersseq_pkg::ST_SLEEP};
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("Stop sequence abandoned");

  property p_pend_set;
    state_q == ersseq_pkg::ST_STOP && cif.reset_ok |=> reset_pending_q;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("Reset during power-down not held pending");

  property p_reset_stop;
    state_q == ersseq_pkg::ST_RUN && cif.enable_ok && cif.reset_ok
      && enable_polarity == pol_q
      |=> state_q == ersseq_pkg::ST_RST_STOP ##1 !motor_en_q;
  endproperty
  a_reset_stop: assert property (p_reset_stop)
    else $error("Reset while enabled did not stop motor");

  property p_reload;
    state_q == ersseq_pkg::ST_RELOAD
      |-> otp_reload_q && fault_clear_q && datapath_init_q
          ##1 !otp_reload_q;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Reload pulse wrong");

  property p_hold;
    state_q == ersseq_pkg::ST_RST_HOLD && cif.reset_ok
      |-> !motor_en_q [*2];
  endproperty
  a_hold: assert property (p_hold)
    else $error("Motor enabled while reset held");

  property p_wake_run;
    state_q == ersseq_pkg::ST_SLEEP && cif.enable_ok && !reset_pending_q && !cif.reset_ok
      |=> state_q == ersseq_pkg::ST_RUN && motor_en_q;
  endproperty
  a_wake_run: assert property (p_wake_run)
    else $error("Enable in sleep did not restart motor");

  property p_wake_reload;
    state_q == ersseq_pkg::ST_SLEEP && cif.enable_ok && reset_pending_q
      |=> state_q == ersseq_pkg::ST_RELOAD && otp_reload_q;
  endproperty
  a_wake_reload: assert property (p_wake_reload)
    else $error("Pending reset not acted on at wake");

  property p_pend_clear;
    state_q == ersseq_pkg::ST_RELOAD |=> !reset_pending_q;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("Pending reset kept after reload");

  property p_rst_quiet;
    state_q == ersseq_pkg::ST_RST_STOP && !at_limit(quiet_q, STOP_CYCLES)
      |=> !otp_reload_q;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("Reload before full stopped interval");

  c_sleep: cover property (
    state_q == ersseq_pkg::ST_STOP ##1 state_q == ersseq_pkg::ST_SLEEP);
  c_wake: cover property (
    state_q == ersseq_pkg::ST_SLEEP ##1 state_q == ersseq_pkg::ST_RUN);
  c_rst_reload: cover property (
    state_q == ersseq_pkg::ST_RST_STOP ##1 state_q == ersseq_pkg::ST_RELOAD);
  c_pend_reload: cover property (
    state_q == ersseq_pkg::ST_SLEEP && reset_pending_q
    ##1 state_q == ersseq_pkg::ST_RELOAD);

endmodule : ersseq_top

`default_nettype wire

// ===== ersseq_host.sv
`timescale 1ns/1ps
`default_nettype none

module ersseq_host (
  input wire logic clk,
  output var logic enable_pin,
  output var logic reset_pin,
  output var logic speed_pulse_out
);
  initial begin
    enable_pin = 1'b0;
    reset_pin = 1'b0;
    speed_pulse_out = 1'b0;
  end

  // Separate pins, caller holds each level long enough
  task automatic pins(input logic en, input logic rst);
    enable_pin = en;
    reset_pin = rst;
  endtask : pins

  // Shared wire, used only with enable active low
  task automatic tied(input logic lvl);
    enable_pin = lvl;
    reset_pin = lvl;
  endtask : tied

  // Motor coasting down, one edge per cycle
  task automatic spin(input int cnt);
    repeat (cnt) begin
      @(negedge clk);
      speed_pulse_out = ~speed_pulse_out;
    end
  endtask : spin
endmodule : ersseq_host

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int STOP = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic brake_mode_select = 1'b0;
  logic enable_polarity = 1'b0;
  logic enable_pin;
  logic reset_pin;
  logic speed_pulse_out;
  logic motor_en_q;
  logic brake_q;
  logic core_power_q;
  logic sensor_supply_en_q;
  logic power_switch_en_q;
  logic clocks_run_q;
  logic logic_en_q;
  logic serial_if_en_q;
  logic otp_reload_q;
  logic fault_clear_q;
  logic datapath_init_q;
  logic reset_pending_q;
  int fail_count = 0;
  int tests_run = 0;
  int n;

  always #2.5 clk = ~clk;

  ersseq_top #(.STOP_CYCLES(ersseq_pkg::ersseq_cnt_t'(STOP))) u_ersseq_top (
    .clk, .reset_n, .enable_pin, .reset_pin, .speed_pulse_out,
    .brake_mode_select, .enable_polarity, .motor_en_q, .brake_q,
    .core_power_q, .sensor_supply_en_q, .power_switch_en_q, .clocks_run_q,
    .logic_en_q, .serial_if_en_q, .otp_reload_q, .fault_clear_q,
    .datapath_init_q, .reset_pending_q
  );

  ersseq_host u_ersseq_host (.clk, .enable_pin, .reset_pin, .speed_pulse_out);

  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask : check

  function automatic logic sig(input int s);
    case (s)
      0: return motor_en_q;
      1: return core_power_q;
      default: return otp_reload_q;
    endcase
  endfunction : sig

  task automatic wait_sig(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(sig(s), v);
  endtask : wait_sig

  task automatic stay(input int s, input logic v, input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (sig(s) !== v) bad++;
    end
    check(bad == 0, 1'b1);
  endtask : stay

  task automatic awake(input logic v);
    check(core_power_q, v);
    check(sensor_supply_en_q, v);
    check(power_switch_en_q, v);
    check(clocks_run_q, v);
    check(logic_en_q, v);
    check(serial_if_en_q, 1'b1);
  endtask : awake

  task automatic t_wake();
    awake(1'b0);
    check(reset_pending_q, 1'b0);
    u_ersseq_host.pins(1'b1, 1'b0);
    wait_sig(0, 1'b1, 300);
    check(n >= 240 && n <= 246, 1'b1);
    awake(1'b1);
  endtask : t_wake

  task automatic t_glitch();
    u_ersseq_host.pins(1'b0, 1'b0);
    repeat (100) @(negedge clk);
    u_ersseq_host.pins(1'b1, 1'b0);
    stay(0, 1'b1, 300);
  endtask : t_glitch

  task automatic t_stop();
    u_ersseq_host.pins(1'b0, 1'b0);
    wait_sig(0, 1'b0, 300);
    check(n >= 240 && n <= 246, 1'b1);
    check(brake_q, 1'b0);
    u_ersseq_host.pins(1'b1, 1'b0);
    u_ersseq_host.spin(10);
    check(core_power_q, 1'b1);
    wait_sig(1, 1'b0, 40);
    check(n >= STOP && n <= STOP + 6, 1'b1);
    awake(1'b0);
    wait_sig(0, 1'b1, 300);
  endtask : t_stop

  task automatic t_rst_run();
    brake_mode_select = 1'b1;
    u_ersseq_host.pins(1'b1, 1'b1);
    wait_sig(0, 1'b0, 10);
    check(n <= 4, 1'b1);
    check(brake_q, 1'b1);
    wait_sig(2, 1'b1, 40);
    check(n >= STOP - 2, 1'b1);
    check(fault_clear_q, 1'b1);
    check(datapath_init_q, 1'b1);
    stay(2, 1'b0, 5);
    stay(0, 1'b0, 100);
    u_ersseq_host.pins(1'b1, 1'b0);
    wait_sig(0, 1'b1, 10);
  endtask : t_rst_run

  task automatic t_rst_sleep();
    u_ersseq_host.pins(1'b0, 1'b0);
    wait_sig(0, 1'b0, 300);
    u_ersseq_host.pins(1'b0, 1'b1);
    repeat (5) @(negedge clk);
    u_ersseq_host.pins(1'b0, 1'b0);
    check(reset_pending_q, 1'b1);
    wait_sig(1, 1'b0, 40);
    check(reset_pending_q, 1'b1);
    u_ersseq_host.pins(1'b1, 1'b0);
    wait_sig(2, 1'b1, 300);
    wait_sig(0, 1'b1, 5);
    check(reset_pending_q, 1'b0);
  endtask : t_rst_sleep

  task automatic t_pol();
    enable_polarity = 1'b1;
    u_ersseq_host.pins(1'b0, 1'b0);
    wait_sig(0, 1'b0, 10);
    wait_sig(1, 1'b0, 40);
    wait_sig(0, 1'b1, 300);
  endtask : t_pol

  task automatic t_tied();
    u_ersseq_host.tied(1'b1);
    wait_sig(0, 1'b0, 10);
    wait_sig(2, 1'b1, 40);
    check(fault_clear_q, 1'b1);
    stay(0, 1'b0, 300);
    u_ersseq_host.tied(1'b0);
    stay(2, 1'b0, 200);
    wait_sig(0, 1'b1, 100);
    check(n >= 40 && n <= 46, 1'b1);
  endtask : t_tied

  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_wake();
    t_glitch();
    t_stop();
    t_rst_run();
    t_rst_sleep();
    t_pol();
    t_tied();
    wrap_up();
  end

  initial begin
    repeat (20000) @(negedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
